// ==== hdl/sram_ctrl.sv ====
`timescale 1ns/1ps
// Behaviour
// R1 - The memory holds 256 words of 4 bits chosen by an 8-bit address.
// R2 - With the chip selected and read/write low, the memory writes the data input value.
// R3 - With the chip selected and read/write high, the memory drives the addressed word out.
// R4 - Chip select low-active high or high-active low deselects, blocking reads and writes.
// R5 - While deselected the data outputs float.
// R6 - Output float control high floats the data outputs for a shared data bus.
// R7 - Read data is valid at most 180 ns after the chip is selected.
// R8 - Read data is valid 130 or 150 ns, by grade, after output float control falls.
// R9 - Outputs float within 100 ns of the first deselect edge or float control rising.
// R10 - Old output data stays valid at least 40 ns after an address change.
// R11 - The address is stable at least 20 ns before read/write falls for a write.
// R12 - On a shared bus float control is high at least 20 ns before write data is driven.
// R13 - The chip is selected at least 150, 200 or 250 ns by grade before the write pulse ends.
// R14 - Output float control may stay low all cycle unless inputs and outputs share a bus.
// R15 - The chip is deselected before the supply is lowered, with zero setup.
// R16 - After the supply returns, one read cycle time passes before a new access.
// R17 - Write data is taken at the trailing edge of the write pulse.
module sram_ctrl #(
  parameter int GRADE = 0,
  parameter bit COMMON_IO = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // User request
  input wire logic req_valid_i,
  input wire sram_pkg::sram_req_s req_i,
  output logic req_ready_o,
  // User response
  output logic resp_valid_o,
  output logic [sram_pkg::DATA_W-1:0] resp_data_o,
  // Power-down control
  input wire logic pd_req_i,
  output logic supply_low_o,
  // Memory pins
  output sram_pkg::sram_pin_s pins_o,
  input wire logic [sram_pkg::DATA_W-1:0] dout_i
);

  // ****************************************
  // Timing and state
  // ****************************************
  localparam int RD_N = sram_pkg::RD_CYC[GRADE];
  // R13 select before end: pulse covers select setup
  localparam int WP_N = sram_pkg::WP_CYC[GRADE];
  localparam int REC_N = sram_pkg::max2(1, sram_pkg::WC_CYC[GRADE] - sram_pkg::ASU_CYC - WP_N);
  localparam int RC_N = sram_pkg::RC_CYC[GRADE];
  localparam int ASU_N = sram_pkg::ASU_CYC;
  localparam int PDSU_N = sram_pkg::PDSU_CYC;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RD = 8'h02,
    ST_WSU = 8'h04,
    ST_WP = 8'h08,
    ST_WREC = 8'h10,
    ST_PDEN = 8'h20,
    ST_PDHOLD = 8'h40,
    ST_PDREC = 8'h80
  } sram_state_e;

  sram_state_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  sram_pkg::sram_req_s req_r;
  sram_pkg::sram_pin_s pins_r, pins_nxt;
  logic [sram_pkg::DATA_W-1:0] rdata;
  logic resp_r, resp_nxt;
  logic [sram_pkg::DATA_W-1:0] resp_data_r;
  logic supply_low_r, supply_low_nxt;

  wire cnt_done = (cnt_r == 8'h00);
  wire accept = (state_r == ST_IDLE) && !pd_req_i && req_valid_i;
  wire sram_pkg::sram_req_s cur = accept ? req_i : req_r;

  sram_sync3 #(.W(sram_pkg::DATA_W)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(dout_i),
    .val_o(rdata)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? 8'h00 : cnt_r - 8'h01;
    resp_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (pd_req_i) begin
          state_nxt = ST_PDEN;
          cnt_nxt = 8'(PDSU_N - 1);
        end else if (req_valid_i) begin
          state_nxt = req_i.write ? ST_WSU : ST_RD;
          cnt_nxt = req_i.write ? 8'(ASU_N - 1) : 8'(RD_N - 1);
        end
      end
      ST_RD: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
          resp_nxt = 1'b1;
        end
      end
      ST_WSU: begin
        if (cnt_done) begin
          state_nxt = ST_WP;
          cnt_nxt = 8'(WP_N - 1);
        end
      end
      ST_WP: begin
        if (cnt_done) begin
          state_nxt = ST_WREC;
          cnt_nxt = 8'(REC_N - 1);
        end
      end
      ST_WREC: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_PDEN: begin
        if (cnt_done) begin
          state_nxt = ST_PDHOLD;
        end
      end
      ST_PDHOLD: begin
        if (!pd_req_i) begin
          state_nxt = ST_PDREC;
          // R16 recovery wait: one read cycle before ready
          cnt_nxt = 8'(RC_N - 1);
        end
      end
      ST_PDREC: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Pin drive per next state
  // ****************************************
  wire sel_nxt = (state_nxt == ST_RD) || (state_nxt == ST_WSU) ||
                 (state_nxt == ST_WP) || (state_nxt == ST_WREC);
  wire wr_nxt = (state_nxt == ST_WSU) || (state_nxt == ST_WP) || (state_nxt == ST_WREC);
  // R11 addr stable: address held from setup through recovery
  wire [sram_pkg::ADDR_W-1:0] addr_nxt = sel_nxt ? cur.addr : pins_r.addr;
  // R12 float before data: shared bus drives data only from the pulse on
  wire oe_nxt = wr_nxt && (!COMMON_IO || (state_nxt != ST_WSU));
  // R14 float held low: float rises only on a shared bus
  wire float_nxt = COMMON_IO && (wr_nxt || !sel_nxt);

  always_comb begin
    pins_nxt.addr = addr_nxt;
    // R2 write strobe: read/write low only in the pulse, chip selected
    pins_nxt.rw = (state_nxt != ST_WP);
    // R15 deselect first: select only during accesses
    pins_nxt.cs1_n = !sel_nxt;
    pins_nxt.cs2 = sel_nxt;
    pins_nxt.output_float_control = float_nxt;
    // R17 data held: input data unchanged through the pulse end
    pins_nxt.din = wr_nxt ? cur.data : pins_r.din;
    pins_nxt.din_oe = oe_nxt;
    supply_low_nxt = (state_nxt == ST_PDHOLD);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      pins_r <= sram_pkg::PIN_RESET;
      pins_r.output_float_control <= COMMON_IO;
      resp_r <= 1'b0;
      supply_low_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
      resp_r <= resp_nxt;
      supply_low_r <= supply_low_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      req_r <= '0;
      resp_data_r <= 4'h0;
    end else begin
      if (accept) begin
        req_r <= req_i;
      end
      if (resp_nxt) begin
        resp_data_r <= rdata;
      end
    end
  end

  assign req_ready_o = (state_r == ST_IDLE) && !pd_req_i;
  assign resp_valid_o = resp_r;
  assign resp_data_o = resp_data_r;
  assign supply_low_o = supply_low_r;
  assign pins_o = pins_r;

  // ****************************************
  // Checks
  // ****************************************
  wire selected = !pins_r.cs1_n && pins_r.cs2;
  logic [7:0] sel_cnt_r;
  logic [7:0] up_cnt_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sel_cnt_r <= 8'h00;
      up_cnt_r <= 8'hFF;
    end else begin
      sel_cnt_r <= !selected ? 8'h00 : (sel_cnt_r == 8'hFF ? 8'hFF : sel_cnt_r + 8'h01);
      up_cnt_r <= supply_low_r ? 8'h00 : (up_cnt_r == 8'hFF ? 8'hFF : up_cnt_r + 8'h01);
    end
  end

  sequence s_wr_start;
    $fell(pins_r.rw) ##0 selected;
  endsequence

  sequence s_wr_end;
    $rose(pins_r.rw) ##0 selected;
  endsequence

  addr_setup_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R11
    s_wr_start |-> pins_r.addr == $past(pins_r.addr, 1) && pins_r.addr == $past(pins_r.addr, 2))
    else $error("address changed inside write setup");

  float_setup_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R12
    COMMON_IO && $rose(pins_r.din_oe) |->
      $past(pins_r.output_float_control, 1) && $past(pins_r.output_float_control, 2))
    else $error("write data driven without float setup");

  cs_setup_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
    s_wr_end |-> sel_cnt_r >= 8'(ASU_N + WP_N))
    else $error("chip select setup too short at write end");

  float_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
    !COMMON_IO |-> !pins_r.output_float_control)
    else $error("float control raised on separate bus");

  pd_deselect_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R15
    supply_low_r |-> !selected && $past(!selected, 1))
    else $error("supply lowered while selected");

  pd_recover_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
    $rose(selected) |-> up_cnt_r >= 8'(RC_N))
    else $error("access started too soon after power-down");

  write_data_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R2
    s_wr_start |-> pins_r.din_oe ##1 (!pins_r.rw && pins_r.din_oe) [*2])
    else $error("write pulse without data driven");

  capture_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R17
    s_wr_end |-> pins_r.din_oe && pins_r.din == $past(pins_r.din))
    else $error("write data moved at pulse end");

endmodule

// ==== hdl/sram_pkg.sv ====
package sram_pkg;

  // ****************************************
  // Clock and timing figures
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int T_RC_NS [3] = '{250, 350, 450};
  localparam int T_AA_NS [3] = '{250, 350, 450};
  localparam int T_ACS_NS = 180;
  localparam int T_AOD_NS [3] = '{130, 150, 150};
  localparam int T_WC_NS [3] = '{170, 220, 270};
  localparam int T_WP_NS [3] = '{150, 200, 250};
  localparam int T_CSSU_NS [3] = '{150, 200, 250};
  localparam int T_ASU_NS = 20;
  localparam int T_ODSU_NS = 20;
  localparam int T_PDSU_NS = 0;

  // Least times round up to whole cycles, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // ****************************************
  // Cycle counts
  // ****************************************
  localparam int SYNC_LAT_CYC = 5;
  localparam int ASU_CYC = max2(ns2cyc(T_ASU_NS), ns2cyc(T_ODSU_NS));
  localparam int PDSU_CYC = ns2cyc(T_PDSU_NS);
  localparam int RC_CYC [3] = '{ns2cyc(T_RC_NS[0]), ns2cyc(T_RC_NS[1]), ns2cyc(T_RC_NS[2])};
  localparam int RD_CYC [3] = '{
    max2(max2(ns2cyc(T_AA_NS[0]), ns2cyc(T_ACS_NS)), ns2cyc(T_AOD_NS[0])) + SYNC_LAT_CYC,
    max2(max2(ns2cyc(T_AA_NS[1]), ns2cyc(T_ACS_NS)), ns2cyc(T_AOD_NS[1])) + SYNC_LAT_CYC,
    max2(max2(ns2cyc(T_AA_NS[2]), ns2cyc(T_ACS_NS)), ns2cyc(T_AOD_NS[2])) + SYNC_LAT_CYC};
  localparam int WP_CYC [3] = '{
    max2(ns2cyc(T_WP_NS[0]), ns2cyc(T_CSSU_NS[0])),
    max2(ns2cyc(T_WP_NS[1]), ns2cyc(T_CSSU_NS[1])),
    max2(ns2cyc(T_WP_NS[2]), ns2cyc(T_CSSU_NS[2]))};
  localparam int WC_CYC [3] = '{ns2cyc(T_WC_NS[0]), ns2cyc(T_WC_NS[1]), ns2cyc(T_WC_NS[2])};

  // ****************************************
  // Widths, types and reset values
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rw;
    logic cs1_n;
    logic cs2;
    logic output_float_control;
    logic [DATA_W-1:0] din;
    logic din_oe;
  } sram_pin_s;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sram_req_s;

  localparam sram_pin_s PIN_RESET = '{addr: 8'h00, rw: 1'b1, cs1_n: 1'b1, cs2: 1'b0,
                                      output_float_control: 1'b1, din: 4'h0, din_oe: 1'b0};

endpackage

// ==== hdl/sram_sync3.sv ====
`timescale 1ns/1ps
module sram_sync3 #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Pin side
  input wire logic [W-1:0] pin_i,
  // Filtered value
  output logic [W-1:0] val_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] val_r;
  wire agree = (s2_r == s3_r);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      val_r <= '0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        val_r <= s3_r;
      end
    end
  end

  assign val_o = val_r;

endmodule

// ==== tb/sram_dev_model.sv ====
`timescale 1ns/1ps
module sram_dev_model #(
  parameter int GRADE = 0,
  parameter int EXTRA_NS = 0
) (
  // Pins from the controller
  input wire sram_pkg::sram_pin_s pins_i,
  input wire logic supply_low_i,
  // Data out and breaches seen
  output logic [sram_pkg::DATA_W-1:0] dout_o,
  output logic [7:0] viol_cnt_o
);
  logic [sram_pkg::DATA_W-1:0] mem [256];
  logic [sram_pkg::DATA_W-1:0] last = 4'h0;
  longint t_chg = 0;
  longint t_addr = 0;
  longint t_sel = 0;
  longint t_sup = -100000;
  wire sel = !pins_i.cs1_n && pins_i.cs2;
  wire wr = sel && !pins_i.rw;
  wire rd_on = sel && pins_i.rw && !pins_i.output_float_control;
  wire [7:0] addr = pins_i.addr;
  // Only real high-to-low steps count, not the first leave of unknown
  logic wr_d = 1'b0;
  logic sup_d = 1'b0;

  initial viol_cnt_o = 8'h00;
  initial dout_o = 4'h0;
  always @(addr) t_addr = $time;
  always @(addr or rd_on) t_chg = $time;
  always @(supply_low_i) begin
    if (sup_d === 1'b1 && supply_low_i === 1'b0) t_sup = $time;
    sup_d = supply_low_i;
  end
  always @(posedge sel) begin
    t_sel = $time;
    if ($time - t_sup < sram_pkg::T_RC_NS[GRADE]) viol_cnt_o++;
  end
  always @(negedge pins_i.rw) begin
    if (sel && $time - t_addr < sram_pkg::T_ASU_NS) viol_cnt_o++;
  end
  always @(wr) begin
    if (wr_d === 1'b1 && wr === 1'b0) begin
      if ($time - t_sel < sram_pkg::T_CSSU_NS[GRADE]) viol_cnt_o++;
      mem[addr] = pins_i.din;
    end
    wr_d = wr;
  end
  always @(posedge supply_low_i) begin
    if (sel) viol_cnt_o++;
  end
  always #1 begin
    if (rd_on && $time - t_chg >= sram_pkg::T_AA_NS[GRADE] + EXTRA_NS) begin
      dout_o = mem[addr];
      last = dout_o;
    end else if ($time - t_chg < 40) begin
      dout_o = last;
    end else begin
      dout_o = ~dout_o;
    end
  end
endmodule

// ==== tb/tb_static_ram_256x4.sv ====
`timescale 1ns/1ps
module tb_static_ram_256x4;
  localparam int G = 0;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  sram_pkg::sram_req_s req_i = '0;
  logic pd_req_i = 1'b0;
  logic req_ready_o;
  logic resp_valid_o;
  logic supply_low_o;
  logic [sram_pkg::DATA_W-1:0] resp_data_o;
  logic [sram_pkg::DATA_W-1:0] dout_i;
  sram_pkg::sram_pin_s pins_o;
  logic [7:0] viol_cnt;
  int error_cnt = 0;
  int total_checks = 0;

  always #5 clk_i = ~clk_i;

  sram_ctrl #(.GRADE(G), .COMMON_IO(1'b0)) i_sram_ctrl (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .pd_req_i(pd_req_i),
    .supply_low_o(supply_low_o), .pins_o(pins_o), .dout_i(dout_i));
  sram_dev_model #(.GRADE(G), .EXTRA_NS(0)) i_sram_dev_model (.pins_i(pins_o),
    .supply_low_i(supply_low_o), .dout_o(dout_i), .viol_cnt_o(viol_cnt));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [3:0] pat(input logic [7:0] a);
    return a[3:0] ^ a[7:4] ^ 4'h5;
  endfunction

  task automatic send(input logic wr, input logic [7:0] a, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{write: wr, addr: a, data: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 200);
    req_valid_i <= 1'b0;
    chk(req_ready_o, 32'h1);
  endtask

  task automatic wait_resp(input int exp_k, input logic [3:0] exp);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      #1;
      k++;
    end while (resp_valid_o !== 1'b1 && k < 100);
    chk(k, exp_k);
    chk(resp_data_o, exp);
    @(posedge clk_i);
    #1;
    chk(resp_valid_o, 32'h0);
    chk(pins_o.cs1_n, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [3:0] exp);
    send(1'b0, a, 4'h0);
    wait_resp(sram_pkg::RD_CYC[G], exp);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    #1;
    chk(pins_o.cs1_n, 32'h1);
    chk(pins_o.cs2, 32'h0);
    chk(supply_low_o, 32'h0);
    chk(resp_valid_o, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_fill();
    for (int i = 0; i < 256; i++) send(1'b1, 8'(i), pat(8'(i)));
    for (int i = 255; i >= 0; i--) rd(8'(i), pat(8'(i)));
    send(1'b1, 8'hA5, 4'hC);
    rd(8'hA5, 4'hC);
    $display("test_fill done");
  endtask

  task automatic test_busy();
    send(1'b0, 8'h10, 4'h0);
    #1;
    chk(req_ready_o, 32'h0);
    chk(pins_o.cs1_n, 32'h0);
    chk(pins_o.cs2, 32'h1);
    chk(pins_o.addr, 32'h10);
    chk(pins_o.output_float_control, 32'h0);
    wait_resp(sram_pkg::RD_CYC[G], pat(8'h10));
    $display("test_busy done");
  endtask

  task automatic test_pd();
    int k;
    @(posedge clk_i);
    pd_req_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      #1;
      k++;
    end while (supply_low_o !== 1'b1 && k < 20);
    chk(k, 32'h2);
    chk(pins_o.cs1_n, 32'h1);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(req_ready_o, 32'h0);
    req_valid_i <= 1'b0;
    pd_req_i <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (req_ready_o !== 1'b1 && k < 200);
    chk(k >= sram_pkg::RC_CYC[G], 32'h1);
    rd(8'h33, pat(8'h33));
    $display("test_pd done");
  endtask

  initial begin
    repeat (11) @(posedge clk_i);
    test_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    test_fill();
    test_busy();
    test_pd();
    chk(viol_cnt, 32'h0);
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end
endmodule
